/* File: hw/ocd_decoder.sv */
/*
 * instruction-field decoder with an apb status/control slave.
 * assumes the fetch stage presents a word with its configuration in one
 * cycle and the pipeline reads the registered result one cycle later.
 */
module ocd_decoder
	import ocd_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic in_valid, // instruction word present
	input wire logic [31:0] in_word, // instruction word
	input wire ocd_cfg_s in_cfg, // configuration of this word
	output logic out_valid, // decoded result present
	output ocd_result_s out_res // decoded result
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// flags gathered while walking the tables, resolved afterwards
	function automatic ocd_result_s decode(input logic [31:0] w,
		input ocd_cfg_s c);
		ocd_op_e op;
		logic rsvd;
		logic need64;
		logic need_r2;
		logic is_cp0;
		logic is_cp1;
		logic [5:0] opc;
		logic [5:0] fn;
		logic [4:0] rs;
		logic [4:0] rt;
		logic [4:0] rd;
		logic [4:0] sa;
		ocd_result_s r;
		op = OP_UNKNOWN;
		rsvd = 1'b0;
		need64 = 1'b0;
		need_r2 = 1'b0;
		is_cp0 = 1'b0;
		is_cp1 = 1'b0;
		opc = w[OCD_OPC_HI:OCD_OPC_LO];
		fn = w[OCD_FN_HI:OCD_FN_LO];
		rs = w[OCD_RS_HI:OCD_RS_LO];
		rt = w[OCD_RT_HI:OCD_RT_LO];
		rd = w[OCD_RD_HI:OCD_RD_LO];
		sa = w[OCD_SA_HI:OCD_SA_LO];
		case (opc)
			OCD_OP_ADD_IMMEDIATE_WORD: op = OP_ADD_IMMEDIATE_WORD;
			OCD_OP_DOUBLEWORD_ADD_IMMEDIATE:
			begin
				op = OP_DOUBLEWORD_ADD_IMMEDIATE;
				need64 = 1'b1;
			end
			OCD_OP_LB: op = OP_LB;
			OCD_OP_SB: op = OP_SB;
			OCD_OP_LL: op = OP_LL;
			OCD_OP_SC: op = OP_SC;
			OCD_OP_SPECIAL:
			begin
				case (fn)
					OCD_FN_SLL:
					begin
						if (rt != '0 || rd != '0)
							op = OP_SLL;
						else if (sa == '0)
							op = OP_NOP;
						else if (sa == OCD_SA_SUPERSCALAR_NO_OPERATION)
							op = OP_SUPERSCALAR_NO_OPERATION;
						else if (sa == OCD_SA_EHB)
							op = OP_EHB;
						else
							op = OP_SLL;
					end
					OCD_FN_JR: op = w[OCD_BIT_HINT] ? OP_JUMP_REGISTER_WITH_BARRIER : OP_JR;
					OCD_FN_JALR: op = w[OCD_BIT_HINT] ? OP_JALR_HB : OP_JALR;
					OCD_FN_MOVE_FROM_HI: op = OP_MOVE_FROM_HI;
					OCD_FN_SIGNED_WORD_PRODUCT: op = OP_SIGNED_WORD_PRODUCT;
					OCD_FN_ADD: op = OP_ADD;
					OCD_FN_RSVD_R5: rsvd = 1'b1;
					OCD_FN_TGE: op = OP_TGE;
					OCD_FN_DSLL:
					begin
						op = OP_DSLL;
						need64 = 1'b1;
					end
					OCD_FN_CONDITIONAL_MOVE_CLASS:
					begin
						op = w[OCD_BIT_TF] ? OP_MOVE_ON_FP_TRUE : OP_MOVE_ON_FP_FALSE;
						is_cp1 = 1'b1;
					end
					// release 1 ignores the rotate bit entirely
					OCD_FN_SRL:
						op = (c.release2 && w[OCD_BIT_ROT_IMM]) ?
							OP_ROTR : OP_SRL;
					OCD_FN_SHIFT_RIGHT_LOGICAL_VARIABLE:
						op = (c.release2 && w[OCD_BIT_ROT_VAR]) ?
							OP_ROTATE_RIGHT_VARIABLE : OP_SHIFT_RIGHT_LOGICAL_VARIABLE;
					OCD_FN_DOUBLEWORD_SHIFT_RIGHT_LOGICAL_VARIABLE:
					begin
						op = (c.release2 && w[OCD_BIT_ROT_VAR]) ?
							OP_DOUBLEWORD_ROTATE_RIGHT_VARIABLE : OP_DOUBLEWORD_SHIFT_RIGHT_LOGICAL_VARIABLE;
						need64 = 1'b1;
					end
					OCD_FN_DOUBLEWORD_SHIFT_RIGHT_LOGICAL:
					begin
						op = (c.release2 && w[OCD_BIT_ROT_IMM]) ?
							OP_DOUBLEWORD_ROTATE_RIGHT : OP_DOUBLEWORD_SHIFT_RIGHT_LOGICAL;
						need64 = 1'b1;
					end
					OCD_FN_DOUBLEWORD_SHIFT_RIGHT_PLUS32:
					begin
						op = (c.release2 && w[OCD_BIT_ROT_IMM]) ?
							OP_DOUBLEWORD_ROTATE_RIGHT_PLUS32 : OP_DOUBLEWORD_SHIFT_RIGHT_PLUS32;
						need64 = 1'b1;
					end
					default: op = OP_UNKNOWN;
				endcase
			end
			OCD_OP_BRANCH_TRAP_IMMEDIATE_CLASS:
			begin
				if (rt[4:3] == OCD_RT_ROW_RSVD)
					rsvd = 1'b1;
				else if (rt == OCD_RT_BRANCH_IF_NEGATIVE)
					op = OP_BRANCH_IF_NEGATIVE;
				else if (rt == OCD_RT_TRAP_IF_GREATER_EQUAL_IMMEDIATE)
					op = OP_TRAP_IF_GREATER_EQUAL_IMMEDIATE;
				else if (rt == OCD_RT_BRANCH_IF_NEGATIVE_AND_LINK)
					op = OP_BRANCH_IF_NEGATIVE_AND_LINK;
			end
			OCD_OP_SECOND_REGISTER_OP_CLASS:
			begin
				if (fn == OCD_FN_MULTIPLY_ACCUMULATE)
					op = OP_MULTIPLY_ACCUMULATE;
				else if (fn == OCD_FN_CLZ)
					op = OP_CLZ;
			end
			OCD_OP_THIRD_REGISTER_OP_CLASS:
			begin
				need_r2 = 1'b1;
				case (fn)
					OCD_FN_EXT: op = OP_EXT;
					OCD_FN_WORD_BYTE_SHUFFLE_CLASS:
						if (sa == OCD_SA_WSBH)
							op = OP_WSBH;
					OCD_FN_DOUBLEWORD_BYTE_SHUFFLE_CLASS:
					begin
						need64 = 1'b1;
						if (sa == OCD_SA_DOUBLEWORD_SWAP_BYTES_HALFWORDS)
							op = OP_DOUBLEWORD_SWAP_BYTES_HALFWORDS;
						else if (sa == OCD_SA_DOUBLEWORD_SWAP_HALFWORDS)
							op = OP_DOUBLEWORD_SWAP_HALFWORDS;
					end
					default: rsvd = (fn[2:0] == 3'h0);
				endcase
			end
			OCD_OP_SYSTEM_COPROCESSOR_CLASS:
			begin
				is_cp0 = 1'b1;
				case (rs)
					OCD_RS_MOVE_FROM_SYSTEM_COPROCESSOR: op = OP_MOVE_FROM_SYSTEM_COPROCESSOR;
					OCD_RS_RDPGPR:
					begin
						op = OP_RDPGPR;
						need_r2 = 1'b1;
					end
					OCD_RS_WRITE_PREVIOUS_SHADOW_REGISTER:
					begin
						op = OP_WRITE_PREVIOUS_SHADOW_REGISTER;
						need_r2 = 1'b1;
					end
					OCD_RS_MACHINE_CONTROL_MOVE:
					begin
						op = w[OCD_BIT_SC] ? OP_EI : OP_DI;
						need_r2 = 1'b1;
					end
					default: op = OP_UNKNOWN;
				endcase
			end
			OCD_OP_FP_COPROCESSOR_CLASS:
			begin
				is_cp1 = 1'b1;
				if (rs[4:3] == OCD_RS_ROW_MOVE)
				begin
					case (rs[2:0])
						3'h0: op = OP_MOVE_WORD_FROM_FP;
						3'h1:
						begin
							op = OP_MOVE_DOUBLEWORD_FROM_FP;
							need64 = 1'b1;
						end
						3'h2: op = OP_MOVE_FROM_FP_CONTROL;
						3'h3:
						begin
							op = OP_MFHC1;
							need_r2 = 1'b1;
						end
						3'h4: op = OP_MTC1;
						3'h5:
						begin
							op = OP_DMTC1;
							need64 = 1'b1;
						end
						3'h6: op = OP_CTC1;
						default:
						begin
							op = OP_MTHC1;
							need_r2 = 1'b1;
						end
					endcase
				end
				else if (rs == OCD_RS_FMT_S && fn[5:3] == 3'h0)
				begin
					case (fn[2:0])
						3'h0: op = OP_FADD_S;
						3'h1: op = OP_FSUB_S;
						3'h2: op = OP_FMUL_S;
						3'h3: op = OP_FDIV_S;
						3'h4: op = OP_FSQRT_S;
						3'h5: op = OP_FABS_S;
						3'h6: op = OP_FMOV_S;
						default: op = OP_FNEG_S;
					endcase
				end
			end
			default: op = OP_UNKNOWN;
		endcase
		r.op = op;
		r.ri = 1'b0;
		r.cpu = 1'b0;
		// inaccessible coprocessor wins over every reserved test on it
		if ((is_cp0 && !c.cp0_usable) || (is_cp1 && !c.cp1_usable))
			r.cpu = 1'b1;
		else if (rsvd)
			r.ri = 1'b1;
		else if (need_r2 && !c.release2)
			r.ri = 1'b1;
		else if (need64 && !c.ops64)
			r.ri = 1'b1;
		if (r.ri || r.cpu)
			r.op = OP_RESERVED;
		return r;
	endfunction

	// ----------------------------------------------------------------
	// control register and effective configuration
	// ----------------------------------------------------------------
	logic [1:0] ctrl;
	logic [OCD_CNT_W-1:0] ri_count;
	ocd_cfg_s eff_cfg;
	ocd_result_s next_res;
	logic wr_en;
	logic rd_en;

	// software can only narrow what the pipeline grants, never widen it
	always_comb
	begin
		eff_cfg = in_cfg;
		eff_cfg.release2 = in_cfg.release2 && !ctrl[OCD_CTRL_FORCE_R1];
		eff_cfg.ops64 = in_cfg.ops64 && !ctrl[OCD_CTRL_FORCE_32];
		next_res = decode(in_word, eff_cfg);
	end

	// ----------------------------------------------------------------
	// result register
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			out_valid <= 1'b0;
			out_res <= '{op: OP_UNKNOWN, ri: 1'b0, cpu: 1'b0};
		end
		else
		begin
			out_valid <= in_valid;
			if (in_valid)
				out_res <= next_res;
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !pwrite;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ctrl <= OCD_CTRL_RESET;
		else if (wr_en && paddr == OCD_REG_CTRL)
			ctrl <= pwdata[1:0];
	end

	// a software clear and a new exception in the same cycle leave a count of one
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ri_count <= '0;
		else if (in_valid && next_res.ri)
		begin
			if (wr_en && paddr == OCD_REG_RICOUNT)
				ri_count <= OCD_CNT_W'(1);
			else if (ri_count != '1)
				ri_count <= ri_count + OCD_CNT_W'(1);
		end
		else if (wr_en && paddr == OCD_REG_RICOUNT)
			ri_count <= '0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pslverr <= !(paddr == OCD_REG_CTRL || paddr == OCD_REG_STATUS ||
				paddr == OCD_REG_RICOUNT);
			prdata <= '0;
			if (rd_en)
			begin
				case (paddr)
					OCD_REG_CTRL: prdata <= {30'h0, ctrl};
					OCD_REG_STATUS:
						prdata <= {22'h0, out_valid, out_res.cpu, out_res.ri,
							out_res.op};
					OCD_REG_RICOUNT: prdata <= {16'h0, ri_count};
					default: prdata <= '0;
				endcase
			end
		end
	end

endmodule

/* File: hw/ocd_pkg.sv */
/*
 * shared constants, operation codes and carrier structs of the
 * instruction-field decoder.
 * assumes a 32-bit instruction word and the core clock domain.
 */
package ocd_pkg;

	// ----------------------------------------------------------------
	// instruction field positions
	// ----------------------------------------------------------------
	localparam int OCD_OPC_HI = 31;
	localparam int OCD_OPC_LO = 26;
	localparam int OCD_RS_HI = 25;
	localparam int OCD_RS_LO = 21;
	localparam int OCD_RT_HI = 20;
	localparam int OCD_RT_LO = 16;
	localparam int OCD_RD_HI = 15;
	localparam int OCD_RD_LO = 11;
	localparam int OCD_SA_HI = 10;
	localparam int OCD_SA_LO = 6;
	localparam int OCD_FN_HI = 5;
	localparam int OCD_FN_LO = 0;
	localparam int OCD_BIT_TF = 16;
	localparam int OCD_BIT_ROT_IMM = 21;
	localparam int OCD_BIT_ROT_VAR = 6;
	localparam int OCD_BIT_HINT = 10;
	localparam int OCD_BIT_SC = 5;

	// ----------------------------------------------------------------
	// primary opcodes (row, column)
	// ----------------------------------------------------------------
	localparam logic [5:0] OCD_OP_SPECIAL = 6'h00;
	localparam logic [5:0] OCD_OP_BRANCH_TRAP_IMMEDIATE_CLASS = 6'h01;
	localparam logic [5:0] OCD_OP_ADD_IMMEDIATE_WORD = 6'h08;
	localparam logic [5:0] OCD_OP_SYSTEM_COPROCESSOR_CLASS = 6'h10;
	localparam logic [5:0] OCD_OP_FP_COPROCESSOR_CLASS = 6'h11;
	localparam logic [5:0] OCD_OP_DOUBLEWORD_ADD_IMMEDIATE = 6'h18;
	localparam logic [5:0] OCD_OP_SECOND_REGISTER_OP_CLASS = 6'h1c;
	localparam logic [5:0] OCD_OP_THIRD_REGISTER_OP_CLASS = 6'h1f;
	localparam logic [5:0] OCD_OP_LB = 6'h20;
	localparam logic [5:0] OCD_OP_SB = 6'h28;
	localparam logic [5:0] OCD_OP_LL = 6'h30;
	localparam logic [5:0] OCD_OP_SC = 6'h38;

	// ----------------------------------------------------------------
	// function, rt, sa and rs codes of the sub-tables
	// ----------------------------------------------------------------
	localparam logic [5:0] OCD_FN_SLL = 6'h00;
	localparam logic [5:0] OCD_FN_CONDITIONAL_MOVE_CLASS = 6'h01;
	localparam logic [5:0] OCD_FN_SRL = 6'h02;
	localparam logic [5:0] OCD_FN_SHIFT_RIGHT_LOGICAL_VARIABLE = 6'h06;
	localparam logic [5:0] OCD_FN_JR = 6'h08;
	localparam logic [5:0] OCD_FN_JALR = 6'h09;
	localparam logic [5:0] OCD_FN_MOVE_FROM_HI = 6'h10;
	localparam logic [5:0] OCD_FN_DOUBLEWORD_SHIFT_RIGHT_LOGICAL_VARIABLE = 6'h16;
	localparam logic [5:0] OCD_FN_SIGNED_WORD_PRODUCT = 6'h18;
	localparam logic [5:0] OCD_FN_ADD = 6'h20;
	localparam logic [5:0] OCD_FN_RSVD_R5 = 6'h28;
	localparam logic [5:0] OCD_FN_TGE = 6'h30;
	localparam logic [5:0] OCD_FN_DSLL = 6'h38;
	localparam logic [5:0] OCD_FN_DOUBLEWORD_SHIFT_RIGHT_LOGICAL = 6'h3a;
	localparam logic [5:0] OCD_FN_DOUBLEWORD_SHIFT_RIGHT_PLUS32 = 6'h3e;
	localparam logic [5:0] OCD_FN_MULTIPLY_ACCUMULATE = 6'h00;
	localparam logic [5:0] OCD_FN_CLZ = 6'h20;
	localparam logic [5:0] OCD_FN_EXT = 6'h00;
	localparam logic [5:0] OCD_FN_WORD_BYTE_SHUFFLE_CLASS = 6'h20;
	localparam logic [5:0] OCD_FN_DOUBLEWORD_BYTE_SHUFFLE_CLASS = 6'h24;
	localparam logic [4:0] OCD_RT_BRANCH_IF_NEGATIVE = 5'h00;
	localparam logic [4:0] OCD_RT_TRAP_IF_GREATER_EQUAL_IMMEDIATE = 5'h08;
	localparam logic [4:0] OCD_RT_BRANCH_IF_NEGATIVE_AND_LINK = 5'h10;
	localparam logic [1:0] OCD_RT_ROW_RSVD = 2'h3;
	localparam logic [4:0] OCD_SA_SUPERSCALAR_NO_OPERATION = 5'h01;
	localparam logic [4:0] OCD_SA_EHB = 5'h03;
	localparam logic [4:0] OCD_SA_WSBH = 5'h02;
	localparam logic [4:0] OCD_SA_DOUBLEWORD_SWAP_BYTES_HALFWORDS = 5'h02;
	localparam logic [4:0] OCD_SA_DOUBLEWORD_SWAP_HALFWORDS = 5'h05;
	localparam logic [4:0] OCD_RS_MOVE_FROM_SYSTEM_COPROCESSOR = 5'h00;
	localparam logic [4:0] OCD_RS_RDPGPR = 5'h0a;
	localparam logic [4:0] OCD_RS_MACHINE_CONTROL_MOVE = 5'h0b;
	localparam logic [4:0] OCD_RS_WRITE_PREVIOUS_SHADOW_REGISTER = 5'h0e;
	localparam logic [4:0] OCD_RS_FMT_S = 5'h10;
	localparam logic [1:0] OCD_RS_ROW_MOVE = 2'h0;

	// ----------------------------------------------------------------
	// register map (apb, byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OCD_REG_CTRL = 8'h00;
	localparam logic [7:0] OCD_REG_STATUS = 8'h04;
	localparam logic [7:0] OCD_REG_RICOUNT = 8'h08;
	localparam logic [1:0] OCD_CTRL_RESET = 2'h0;
	localparam int OCD_CTRL_FORCE_R1 = 0;
	localparam int OCD_CTRL_FORCE_32 = 1;
	localparam int OCD_CNT_W = 16;

	typedef enum logic [6:0] {
		OP_UNKNOWN, OP_RESERVED, OP_ADD_IMMEDIATE_WORD, OP_DOUBLEWORD_ADD_IMMEDIATE, OP_LB, OP_SB, OP_LL,
		OP_SC, OP_SLL, OP_NOP, OP_SUPERSCALAR_NO_OPERATION, OP_EHB, OP_JR, OP_JUMP_REGISTER_WITH_BARRIER, OP_JALR,
		OP_JALR_HB, OP_MOVE_FROM_HI, OP_SIGNED_WORD_PRODUCT, OP_ADD, OP_TGE, OP_DSLL, OP_SRL,
		OP_ROTR, OP_SHIFT_RIGHT_LOGICAL_VARIABLE, OP_ROTATE_RIGHT_VARIABLE, OP_DOUBLEWORD_SHIFT_RIGHT_LOGICAL_VARIABLE, OP_DOUBLEWORD_ROTATE_RIGHT_VARIABLE, OP_DOUBLEWORD_SHIFT_RIGHT_LOGICAL, OP_DOUBLEWORD_ROTATE_RIGHT,
		OP_DOUBLEWORD_SHIFT_RIGHT_PLUS32, OP_DOUBLEWORD_ROTATE_RIGHT_PLUS32, OP_MOVE_ON_FP_FALSE, OP_MOVE_ON_FP_TRUE, OP_BRANCH_IF_NEGATIVE, OP_TRAP_IF_GREATER_EQUAL_IMMEDIATE,
		OP_BRANCH_IF_NEGATIVE_AND_LINK, OP_MULTIPLY_ACCUMULATE, OP_CLZ, OP_EXT, OP_WSBH, OP_DOUBLEWORD_SWAP_BYTES_HALFWORDS, OP_DOUBLEWORD_SWAP_HALFWORDS,
		OP_MOVE_FROM_SYSTEM_COPROCESSOR, OP_RDPGPR, OP_WRITE_PREVIOUS_SHADOW_REGISTER, OP_DI, OP_EI, OP_MOVE_WORD_FROM_FP, OP_MOVE_DOUBLEWORD_FROM_FP,
		OP_MOVE_FROM_FP_CONTROL, OP_MFHC1, OP_MTC1, OP_DMTC1, OP_CTC1, OP_MTHC1, OP_FADD_S,
		OP_FSUB_S, OP_FMUL_S, OP_FDIV_S, OP_FSQRT_S, OP_FABS_S, OP_FMOV_S,
		OP_FNEG_S
	} ocd_op_e;

	// configuration that travels with each instruction word
	typedef struct packed {
		logic release2;
		logic ops64;
		logic cp0_usable;
		logic cp1_usable;
	} ocd_cfg_s;

	typedef struct packed {
		ocd_op_e op;
		logic ri;
		logic cpu;
	} ocd_result_s;

endpackage

/* File: verification/ocd_monitor.sv */
/*
 * concurrent checks on the decoder ports, bound into ocd_decoder.
 * assumes one clock domain and a synchronous active-high reset.
 */
module ocd_monitor
	import ocd_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic sys_rst, // synchronous reset
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [31:0] prdata, // apb read data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic in_valid, // word present
	input wire logic [31:0] in_word, // instruction word
	input wire ocd_cfg_s in_cfg, // word configuration
	input wire logic out_valid, // result present
	input wire ocd_result_s out_res // decoded result
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	sequence s_take(logic [5:0] opc);
		in_valid && in_word[31:26] == opc;
	endsequence
	sequence s_rsvd;
		out_valid && out_res.ri && out_res.op == OP_RESERVED;
	endsequence

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_answer_next: assert property (in_valid |=> out_valid)
		else $error("result missing one cycle after a word");
	a_no_stray: assert property (!in_valid |=> !out_valid)
		else $error("result without a word");
	a_result_holds: assert property (!in_valid |=> $stable(out_res))
		else $error("result changed without a word");
	a_flag_reserved: assert property (
		out_valid && (out_res.ri || out_res.cpu) |-> out_res.op == OP_RESERVED)
		else $error("flagged result carries an operation");
	a_r1_third: assert property (
		s_take(OCD_OP_THIRD_REGISTER_OP_CLASS) ##0 !in_cfg.release2 |=> s_rsvd)
		else $error("third class accepted in release 1");
	a_branch_trap_immediate_class_row3: assert property (
		s_take(OCD_OP_BRANCH_TRAP_IMMEDIATE_CLASS) ##0 in_word[20:19] == OCD_RT_ROW_RSVD
		|=> s_rsvd)
		else $error("reserved immediate row not flagged");
	a_narrow_64: assert property (
		s_take(OCD_OP_DOUBLEWORD_ADD_IMMEDIATE) ##0 !in_cfg.ops64 |=> s_rsvd)
		else $error("64-bit add accepted without 64-bit mode");
	a_add_immediate_word_plain: assert property (
		s_take(OCD_OP_ADD_IMMEDIATE_WORD) |=> out_res.op == OP_ADD_IMMEDIATE_WORD && !out_res.ri)
		else $error("add immediate misdecoded");
	a_fp_locked: assert property (
		s_take(OCD_OP_FP_COPROCESSOR_CLASS) ##0 !in_cfg.cp1_usable |=> out_valid && out_res.cpu)
		else $error("locked fp coprocessor not flagged");
	a_sys_locked: assert property (
		s_take(OCD_OP_SYSTEM_COPROCESSOR_CLASS) ##0 !in_cfg.cp0_usable |=> out_valid && out_res.cpu)
		else $error("locked system coprocessor not flagged");
	a_r1_shift: assert property (
		s_take(OCD_OP_SPECIAL) ##0
		(in_word[5:0] == OCD_FN_SRL && !in_cfg.release2)
		|=> out_res.op == OP_SRL)
		else $error("release 1 right shift not a shift");
endmodule

bind ocd_decoder ocd_monitor u_mon (
	.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .in_valid(in_valid),
	.in_word(in_word), .in_cfg(in_cfg), .out_valid(out_valid),
	.out_res(out_res)
);

/* File: verification/ocd_pipe_model.sv */
/*
 * fetch stage model: hands one word with its configuration per call.
 * assumes the caller enters issue right at a rising clock edge.
 */
module ocd_pipe_model
	import ocd_pkg::*;
(
	input wire logic clk, // core clock
	output logic in_valid, // word present
	output logic [31:0] in_word, // instruction word
	output ocd_cfg_s in_cfg // configuration of the word
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		in_valid = 1'b0;
		in_word = 32'h0;
		in_cfg = '0;
	end
	task automatic issue(input logic [31:0] w, input ocd_cfg_s c);
		in_valid <= 1'b1;
		in_word <= w;
		in_cfg <= c;
		@(posedge clk);
		in_valid <= 1'b0;
		// stale fields would hide a decoder that samples late
		in_word <= ~w;
		in_cfg <= ~c;
	endtask
endmodule

/* File: verification/tb_isa_opcode_field_decoder.sv */
/*
 * self-checking bench of the instruction-field decoder.
 * assumes ocd_pipe_model feeds words and the checker is bound in.
 */
`define CHK(a, e) \
	begin \
		n_checks++; \
		if ((a) !== (e)) \
		begin \
			n_mismatch++; \
			$display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
		end \
	end

module tb_isa_opcode_field_decoder
	import ocd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam ocd_cfg_s cfg_all = 4'hf;
	localparam ocd_cfg_s cfg_r1 = 4'h7;
	localparam ocd_cfg_s cfg_n64 = 4'hb;
	localparam ocd_cfg_s cfg_ncp1 = 4'he;
	localparam ocd_cfg_s cfg_ncp0 = 4'hd;
	logic clk;
	logic sys_rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic in_valid;
	logic [31:0] in_word;
	ocd_cfg_s in_cfg;
	logic out_valid;
	ocd_result_s out_res;
	int n_checks = 0;
	int n_mismatch = 0;

	ocd_decoder u_dut (
		.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_valid(in_valid),
		.in_word(in_word), .in_cfg(in_cfg), .out_valid(out_valid),
		.out_res(out_res)
	);
	ocd_pipe_model u_pipe (
		.clk(clk), .in_valid(in_valid), .in_word(in_word), .in_cfg(in_cfg)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			end_sim();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// one word in, result looked at mid-cycle after the taking edge
	task automatic dec(input logic [31:0] w, input ocd_cfg_s c,
		input ocd_op_e op, input logic ri = 1'b0, input logic cpu = 1'b0);
		u_pipe.issue(w, c);
		@(negedge clk);
		`CHK(out_valid, 1'b1)
		`CHK(out_res, {op, ri, cpu})
		@(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic sc_regs();
		logic [31:0] r;
		logic e;
		apb(1'b0, OCD_REG_CTRL, 32'h0, r, e);
		`CHK(r, 32'h0)
		`CHK(e, 1'b0)
		apb(1'b1, OCD_REG_RICOUNT, 32'h0, r, e);
		dec(32'h04180000, cfg_all, OP_RESERVED, 1'b1);
		dec(32'h04180000, cfg_all, OP_RESERVED, 1'b1);
		apb(1'b0, OCD_REG_RICOUNT, 32'h0, r, e);
		`CHK(r[15:0], 16'h2)
		// clear and a flagged word meet at the access edge: the word counts
		fork
			apb(1'b1, OCD_REG_RICOUNT, 32'h0, r, e);
			begin
				@(posedge clk);
				dec(32'h04180000, cfg_all, OP_RESERVED, 1'b1);
			end
		join
		apb(1'b0, OCD_REG_RICOUNT, 32'h0, r, e);
		`CHK(r[15:0], 16'h1)
		apb(1'b0, OCD_REG_STATUS, 32'h0, r, e);
		`CHK(r[9:0], {3'b001, 7'(OP_RESERVED)})
		apb(1'b1, OCD_REG_CTRL, 32'h1, r, e);
		dec(32'h7c000000, cfg_all, OP_RESERVED, 1'b1);
		apb(1'b1, OCD_REG_CTRL, 32'h2, r, e);
		dec(32'h60000000, cfg_all, OP_RESERVED, 1'b1);
		apb(1'b1, OCD_REG_CTRL, 32'h0, r, e);
		dec(32'h60000000, cfg_all, OP_DOUBLEWORD_ADD_IMMEDIATE);
		apb(1'b0, 8'h0c, 32'h0, r, e);
		`CHK({e, r}, 33'h100000000)
	endtask

	task automatic sc_primary();
		ocd_op_e t[8] = '{OP_NOP, OP_ADD_IMMEDIATE_WORD, OP_MOVE_FROM_SYSTEM_COPROCESSOR, OP_DOUBLEWORD_ADD_IMMEDIATE, OP_LB,
			OP_SB, OP_LL, OP_SC};
		for (int i = 0; i < 8; i++)
			dec({i[2:0], 29'h0}, cfg_all, t[i]);
		dec(32'h60000000, cfg_n64, OP_RESERVED, 1'b1);
		dec(32'h7c000000, cfg_r1, OP_RESERVED, 1'b1);
		dec(32'h7c000020, cfg_r1, OP_RESERVED, 1'b1);
	endtask

	task automatic sc_reg_class();
		logic [5:0] f[7] = '{OCD_FN_JR, OCD_FN_MOVE_FROM_HI, OCD_FN_SIGNED_WORD_PRODUCT,
			OCD_FN_ADD, OCD_FN_RSVD_R5, OCD_FN_TGE, OCD_FN_DSLL};
		ocd_op_e t[7] = '{OP_JR, OP_MOVE_FROM_HI, OP_SIGNED_WORD_PRODUCT, OP_ADD, OP_RESERVED,
			OP_TGE, OP_DSLL};
		for (int i = 0; i < 7; i++)
			dec({26'h0, f[i]}, cfg_all, t[i], t[i] == OP_RESERVED);
		dec(32'h00000040, cfg_all, OP_SUPERSCALAR_NO_OPERATION);
		dec(32'h000000c0, cfg_all, OP_EHB);
		dec(32'h00021080, cfg_all, OP_SLL);
		dec(32'h00000080, cfg_all, OP_SLL);
		dec(32'h00200408, cfg_all, OP_JUMP_REGISTER_WITH_BARRIER);
		dec(32'h00200409, cfg_all, OP_JALR_HB);
		dec(32'h00200009, cfg_all, OP_JALR);
	endtask

	task automatic sc_imm_class();
		ocd_op_e t[4] = '{OP_BRANCH_IF_NEGATIVE, OP_TRAP_IF_GREATER_EQUAL_IMMEDIATE, OP_BRANCH_IF_NEGATIVE_AND_LINK, OP_RESERVED};
		for (int i = 0; i < 4; i++)
			dec({11'h020, i[1:0], 19'h0}, cfg_all, t[i], i == 3);
	endtask

	task automatic sc_aux();
		dec(32'h70000000, cfg_all, OP_MULTIPLY_ACCUMULATE);
		dec(32'h70000020, cfg_all, OP_CLZ);
		dec(32'h7c000000, cfg_all, OP_EXT);
		dec(32'h7c000008, cfg_all, OP_RESERVED, 1'b1);
		dec(32'h7c0000a0, cfg_all, OP_WSBH);
		dec(32'h7c0000a4, cfg_all, OP_DOUBLEWORD_SWAP_BYTES_HALFWORDS);
		dec(32'h7c000164, cfg_all, OP_DOUBLEWORD_SWAP_HALFWORDS);
		dec(32'h7c0001e0, cfg_all, OP_UNKNOWN);
		dec(32'h00000001, cfg_all, OP_MOVE_ON_FP_FALSE);
		dec(32'h00010001, cfg_all, OP_MOVE_ON_FP_TRUE);
	endtask

	task automatic sc_shift();
		logic [31:0] w[5] = '{32'h00200002, 32'h00000046, 32'h00000056,
			32'h0020003a, 32'h0020003e};
		ocd_op_e t[5] = '{OP_ROTR, OP_ROTATE_RIGHT_VARIABLE, OP_DOUBLEWORD_ROTATE_RIGHT_VARIABLE, OP_DOUBLEWORD_ROTATE_RIGHT,
			OP_DOUBLEWORD_ROTATE_RIGHT_PLUS32};
		// each rotate sits right after its shift in the operation list
		for (int i = 0; i < 5; i++)
		begin
			dec(w[i], cfg_all, t[i]);
			dec(w[i] & ~32'h00200040, cfg_all, ocd_op_e'(t[i] - 1));
			dec(w[i], cfg_r1, ocd_op_e'(t[i] - 1));
		end
	endtask

	task automatic sc_cop();
		logic [31:0] r;
		logic e;
		dec(32'h41400000, cfg_all, OP_RDPGPR);
		dec(32'h41400000, cfg_r1, OP_RESERVED, 1'b1);
		dec(32'h41c00000, cfg_all, OP_WRITE_PREVIOUS_SHADOW_REGISTER);
		dec(32'h41600000, cfg_all, OP_DI);
		dec(32'h41600020, cfg_all, OP_EI);
		dec(32'h41600000, cfg_r1, OP_RESERVED, 1'b1);
		for (int i = 0; i < 8; i++)
			dec({8'h44, i[2:0], 21'h0}, cfg_all, ocd_op_e'(OP_MOVE_WORD_FROM_FP + i));
		for (int i = 0; i < 8; i++)
			dec({11'h230, 18'h0, i[2:0]}, cfg_all, ocd_op_e'(OP_FADD_S + i));
		dec(32'h44200000, cfg_n64, OP_RESERVED, 1'b1);
		dec(32'h44200000, cfg_ncp1, OP_RESERVED, 1'b0, 1'b1);
		dec(32'h44600000, cfg_r1, OP_RESERVED, 1'b1);
		dec(32'h40000000, cfg_ncp0, OP_RESERVED, 1'b0, 1'b1);
		apb(1'b0, OCD_REG_STATUS, 32'h0, r, e);
		`CHK(r[9:0], {3'b010, 7'(OP_RESERVED)})
	endtask

	initial
	begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		sc_regs();
		sc_primary();
		sc_reg_class();
		sc_imm_class();
		sc_aux();
		sc_shift();
		sc_cop();
		end_sim();
	end
endmodule
